// [verilog/asrb_defs.svh]
`ifndef ASRB_DEFS_SVH
`define ASRB_DEFS_SVH
`define ASRB_OFF_WR_CTL 6'h08
`define ASRB_OFF_RD_PTR 6'h0a
`define ASRB_OFF_RD_CTL 6'h0c
`define ASRB_OFF_RD_UPPER 6'h0e
`define ASRB_OFF_RD_LOWER 6'h10
`define ASRB_OFF_CMD 6'h1e
`define ASRB_OFF_POS 6'h20
`define ASRB_OFF_COND 6'h22
`define ASRB_OFF_FAULT 6'h24
`define ASRB_OFF_WARN 6'h26
`define ASRB_GO_BIT 15
`define ASRB_BUSY_BIT 8
`define ASRB_CLS_BIT 10
`define ASRB_CLW_BIT 9
`define ASRB_CLE_BIT 8
`define ASRB_TAG_COND 4'h8
`define ASRB_TAG_FAULT 4'ha
`define ASRB_TAG_WARN 4'hb
`define ASRB_KEY_NVM 8'ha5
`define ASRB_KEY_HRST 8'h5a
`define ASRB_KEY_TURNS 8'h46
`define ASRB_KEY_TEST 8'hb9
`define ASRB_ACT_MLOW 4'h1
`define ASRB_ACT_MHIGH 4'h2
`define ASRB_ACT_TURNS 4'h4
`define ASRB_ACT_RELOAD 4'h5
`define ASRB_ACT_HRST 4'h7
`define ASRB_ACT_AFE 4'h9
`define ASRB_ACT_LOGIC_BUILTIN_SELFTEST 4'ha
`define ASRB_ACT_BOTH 4'hb
`define ASRB_NVM_LAST 8'h1f
`define ASRB_SHD_FIRST 8'h40
`define ASRB_SHD_LAST 8'h5f
`define ASRB_FAULT_RESET 12'h001
`define ASRB_F_WAR 11
`define ASRB_F_UVD 3
`define ASRB_F_UVA 2
`define ASRB_F_RST 0
`define ASRB_W_XEE 7
`define ASRB_W_BSY 2
`define ASRB_CLK_PS 5000
`define ASRB_NVM_RD_NS 2000
`define ASRB_FRAME_BITS 16
`endif

// [verilog/asrb_pkg.sv]
`default_nettype none
package asrb_pkg;
  typedef enum logic [1:0] {ASRB_RD_IDLE, ASRB_RD_NVM, ASRB_RD_SHD} asrb_rd_type;
  typedef struct packed {
    logic [2:0] sck_s;
    logic [2:0] cs_s;
    logic [2:0] mosi_s;
    logic sck_f;
    logic cs_f;
    logic mosi_f;
    logic [4:0] bit_cnt;
    logic [15:0] rx;
    logic [15:0] tx;
    logic miso;
    logic miso_oe;
    logic [5:0] rd_ptr;
    logic [7:0] ra;
    asrb_rd_type rd_st;
    logic rd_done;
    logic [8:0] rd_cnt;
    logic [15:0] rd_hi;
    logic [15:0] rd_lo;
    logic wr_busy;
    logic wr_done;
    logic wr_start;
    logic [3:0] act_sel;
    logic [1:0] margin;
    logic turns_p;
    logic hard_p;
    logic reload_p;
    logic afe_p;
    logic lb_p;
    logic afe_run;
    logic lb_run;
    logic tests_on;
    logic sp_done;
    logic boot_done;
    logic [11:0] fault;
    logic [11:0] fsnap;
    logic [11:0] warn;
    logic [11:0] wsnap;
  } asrb_state_type;
endpackage
`default_nettype wire

// [verilog/asrb_bank.sv]
// Function
// - read_go starts read, reads back zero
// - decode nonvolatile and shadow read addresses
// - result as two read-only halves
// - busy bits high while access pending
// - action_select plus trigger key, clears after except for margin
// - margin and reload need unlock, key a5
// - turns reset key 46, no unlock
// - hard reset needs unlock, key conflict
// - self-tests start with key b9
// - clear_status_done clears special and boot done
// - clear_cautions clears warnings seen at read
// - clear_faults clears faults seen at read
// - bit 15 zero, fault_summary from unmasked
// - undervoltage_flag is masked real-time OR
// - odd parity over angle word
// - low twelve bits carry angle
// - register_tag codes on status and faults
// - special_done clears on trigger, sets done
// - boot and self-test status bits
// - angle_valid and rotation direction bits
// - fault bits latch until read, cleared
// - reset bit on hard reset, uv re-sets
// - write_go starts write, reads back zero
// - locked access terminates with done, warning
// - overlapping access raises overlap warning
`timescale 1ns/1ps
`default_nettype none
`include "asrb_defs.svh"
module asrb_bank import asrb_pkg::*; (
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic ce_in,
  input wire logic spi_sclk_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_mosi_in,
  output logic spi_miso_out,
  output logic spi_miso_oe_out,
  input wire logic [11:0] angle_in,
  input wire logic uv_supply_in,
  input wire logic uv_reg_in,
  input wire logic uv_supply_mask_in,
  input wire logic uv_reg_mask_in,
  input wire logic [11:0] fault_event_in,
  input wire logic [11:0] fault_mask_in,
  input wire logic [11:0] warn_event_in,
  input wire logic [11:0] warn_mask_in,
  input wire logic unlocked_in,
  input wire logic loop_locked_in,
  input wire logic boot_busy_in,
  input wire logic boot_complete_in,
  input wire logic rot_dir_in,
  input wire logic [31:0] nvm_data_in,
  input wire logic [31:0] shadow_data_in,
  input wire logic ext_write_done_in,
  input wire logic afe_test_done_in,
  input wire logic logic_builtin_selftest_done_in,
  output logic [7:0] ext_read_addr_out,
  output logic ext_write_start_out,
  output logic [1:0] margin_out,
  output logic turns_reset_out,
  output logic hard_reset_out,
  output logic nvm_reload_out,
  output logic afe_test_start_out,
  output logic logic_builtin_selftest_start_out
);
  localparam int NVM_CYC = (`ASRB_NVM_RD_NS * 1000 + `ASRB_CLK_PS - 1) / `ASRB_CLK_PS;

  asrb_state_type r;
  asrb_state_type n;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;
  logic frame_ok;
  logic [5:0] wa;
  logic [5:0] ww;
  logic [7:0] wd;
  logic key_wr;
  logic key_ok;
  logic cls_now;
  logic clw_now;
  logic cle_now;
  logic rgo;
  logic wgo;
  logic rd_busy;
  logic fsum;
  logic uvf;
  logic angle_valid;
  logic [15:0] ang_word;
  logic [15:0] rword;
  logic [11:0] fset;
  logic [11:0] wset;

  always_comb begin
    rd_busy = r.rd_st != ASRB_RD_IDLE;
    fsum = |(r.fault & ~fault_mask_in) | |(r.warn & ~warn_mask_in);
    uvf = (uv_supply_in & ~uv_supply_mask_in) | (uv_reg_in & ~uv_reg_mask_in);
    // bit 15 zero, parity makes the word odd
    ang_word = {1'b0, fsum, uvf, ~^{fsum, uvf, angle_in}, angle_in};
    angle_valid = loop_locked_in & ~boot_busy_in;
    case (r.rd_ptr)
      `ASRB_OFF_RD_PTR: rword = {8'h00, r.ra};
      `ASRB_OFF_RD_CTL: rword = {7'h00, rd_busy, 7'h00, r.rd_done};
      `ASRB_OFF_WR_CTL: rword = {7'h00, r.wr_busy, 7'h00, r.wr_done};
      `ASRB_OFF_RD_UPPER: rword = r.rd_hi;
      `ASRB_OFF_RD_LOWER: rword = r.rd_lo;
      `ASRB_OFF_CMD: rword = {r.act_sel, 12'h000};
      `ASRB_OFF_POS: rword = ang_word;
      `ASRB_OFF_COND: begin
        rword = {`ASRB_TAG_COND, 4'h0, rot_dir_in, 1'b0, r.sp_done, r.boot_done,
          r.lb_run, r.afe_run, boot_busy_in, angle_valid};
      end
      `ASRB_OFF_FAULT: rword = {`ASRB_TAG_FAULT, r.fault};
      `ASRB_OFF_WARN: rword = {`ASRB_TAG_WARN, r.warn};
      default: rword = 16'h0000;
    endcase
  end

  always_comb begin
    n = r;
    sck_rise = 1'b0;
    sck_fall = 1'b0;
    cs_fall = 1'b0;
    cs_rise = 1'b0;
    frame_ok = 1'b0;
    wa = r.rx[13:8];
    ww = {r.rx[13:9], 1'b0};
    wd = r.rx[7:0];
    key_wr = 1'b0;
    key_ok = 1'b0;
    cls_now = 1'b0;
    clw_now = 1'b0;
    cle_now = 1'b0;
    rgo = 1'b0;
    wgo = 1'b0;
    fset = fault_event_in;
    wset = warn_event_in;
    n.turns_p = 1'b0;
    n.hard_p = 1'b0;
    n.reload_p = 1'b0;
    n.afe_p = 1'b0;
    n.lb_p = 1'b0;
    n.wr_start = 1'b0;
    // pins cross in three stages, a level counts once stages two and three agree
    n.sck_s = {r.sck_s[1:0], spi_sclk_in};
    n.cs_s = {r.cs_s[1:0], spi_cs_n_in};
    n.mosi_s = {r.mosi_s[1:0], spi_mosi_in};
    if (r.sck_s[1] == r.sck_s[2]) begin
      n.sck_f = r.sck_s[2];
    end
    if (r.cs_s[1] == r.cs_s[2]) begin
      n.cs_f = r.cs_s[2];
    end
    if (r.mosi_s[1] == r.mosi_s[2]) begin
      n.mosi_f = r.mosi_s[2];
    end
    sck_rise = n.sck_f & ~r.sck_f;
    sck_fall = ~n.sck_f & r.sck_f;
    cs_fall = ~n.cs_f & r.cs_f;
    cs_rise = n.cs_f & ~r.cs_f;
    n.miso_oe = ~n.cs_f;
    if (cs_fall) begin
      n.bit_cnt = 5'h00;
      n.miso = rword[15];
      n.tx = {rword[14:0], 1'b0};
      if (r.rd_ptr == `ASRB_OFF_FAULT) begin
        n.fsnap = r.fault;
      end
      if (r.rd_ptr == `ASRB_OFF_WARN) begin
        n.wsnap = r.warn;
      end
    end else if (!r.cs_f) begin
      if (sck_rise) begin
        n.rx = {r.rx[14:0], r.mosi_f};
        if (r.bit_cnt != 5'h1f) begin
          n.bit_cnt = r.bit_cnt + 5'h01;
        end
      end
      if (sck_fall) begin
        n.miso = r.tx[15];
        n.tx = {r.tx[14:0], 1'b0};
      end
    end
    // short, long or bit-15 frames are dropped whole
    frame_ok = cs_rise && r.bit_cnt == 5'(`ASRB_FRAME_BITS) && !r.rx[15];
    if (frame_ok && !r.rx[14]) begin
      n.rd_ptr = ww;
    end
    if (frame_ok && r.rx[14]) begin
      if (ww == `ASRB_OFF_RD_PTR && wa[0]) begin
        n.ra = wd;
      end
      if (ww == `ASRB_OFF_RD_CTL && !wa[0]) begin
        rgo = wd[`ASRB_GO_BIT-8];
      end
      if (ww == `ASRB_OFF_WR_CTL && !wa[0]) begin
        wgo = wd[`ASRB_GO_BIT-8];
      end
      if (ww == `ASRB_OFF_CMD && !wa[0]) begin
        n.act_sel = wd[7:4];
        cls_now = wd[`ASRB_CLS_BIT-8];
        clw_now = wd[`ASRB_CLW_BIT-8];
        cle_now = wd[`ASRB_CLE_BIT-8];
        if (wd[7:4] != `ASRB_ACT_MLOW && wd[7:4] != `ASRB_ACT_MHIGH) begin
          n.margin = 2'h0;
        end
      end
      if (ww == `ASRB_OFF_CMD && wa[0]) begin
        key_wr = 1'b1;
      end
    end

    // extended read
    if (rgo) begin
      if (rd_busy || r.wr_busy) begin
        wset[`ASRB_W_BSY] = 1'b1;
      end
      n.rd_done = 1'b0;
      if (r.ra <= `ASRB_NVM_LAST) begin
        n.rd_st = ASRB_RD_NVM;
        n.rd_cnt = 9'(NVM_CYC - 1);
      end else if (r.ra >= `ASRB_SHD_FIRST && r.ra <= `ASRB_SHD_LAST) begin
        n.rd_st = ASRB_RD_SHD;
        n.rd_cnt = 9'h000;
      end else begin
        n.rd_st = ASRB_RD_IDLE;
        n.rd_done = 1'b1;
        wset[`ASRB_W_XEE] = 1'b1;
      end
    end else if (rd_busy) begin
      if (r.rd_cnt == 9'h000) begin
        n.rd_st = ASRB_RD_IDLE;
        n.rd_done = 1'b1;
        // both halves move together with done
        if (r.rd_st == ASRB_RD_NVM) begin
          n.rd_hi = nvm_data_in[31:16];
          n.rd_lo = nvm_data_in[15:0];
        end else begin
          n.rd_hi = shadow_data_in[31:16];
          n.rd_lo = shadow_data_in[15:0];
        end
      end else begin
        n.rd_cnt = r.rd_cnt - 9'h001;
      end
    end

    // extended write: only the busy and done handshake lives here
    if (wgo) begin
      if (rd_busy || r.wr_busy) begin
        wset[`ASRB_W_BSY] = 1'b1;
      end
      if (!unlocked_in) begin
        n.wr_busy = 1'b0;
        n.wr_done = 1'b1;
        wset[`ASRB_W_XEE] = 1'b1;
      end else begin
        n.wr_busy = 1'b1;
        n.wr_done = 1'b0;
        n.wr_start = 1'b1;
      end
    end else if (r.wr_busy && ext_write_done_in) begin
      n.wr_busy = 1'b0;
      n.wr_done = 1'b1;
    end

    // special actions
    unique case (r.act_sel)
      `ASRB_ACT_MLOW, `ASRB_ACT_MHIGH, `ASRB_ACT_RELOAD: begin
        key_ok = key_wr && wd == `ASRB_KEY_NVM && unlocked_in;
      end
      `ASRB_ACT_HRST: begin
        // both documented keys are accepted
        key_ok = key_wr && unlocked_in && (wd == `ASRB_KEY_HRST || wd == `ASRB_KEY_NVM);
      end
      `ASRB_ACT_TURNS: key_ok = key_wr && wd == `ASRB_KEY_TURNS;
      `ASRB_ACT_AFE, `ASRB_ACT_LOGIC_BUILTIN_SELFTEST, `ASRB_ACT_BOTH: begin
        key_ok = key_wr && wd == `ASRB_KEY_TEST;
      end
      default: key_ok = 1'b0;
    endcase
    if (key_ok) begin
      n.sp_done = 1'b0;
      unique case (r.act_sel)
        `ASRB_ACT_MLOW, `ASRB_ACT_MHIGH: begin
          n.margin = r.act_sel[1:0];
          n.sp_done = 1'b1;
        end
        `ASRB_ACT_TURNS: n.turns_p = 1'b1;
        `ASRB_ACT_RELOAD: n.reload_p = 1'b1;
        `ASRB_ACT_HRST: n.hard_p = 1'b1;
        default: begin
          n.afe_p = r.act_sel[0];
          n.lb_p = r.act_sel[1];
          n.afe_run = r.act_sel[0];
          n.lb_run = r.act_sel[1];
          n.tests_on = 1'b1;
        end
      endcase
      if (r.act_sel != `ASRB_ACT_MLOW && r.act_sel != `ASRB_ACT_MHIGH && !n.tests_on) begin
        n.act_sel = 4'h0;
        n.sp_done = 1'b1;
      end
    end
    if (afe_test_done_in) begin
      n.afe_run = 1'b0;
    end
    if (logic_builtin_selftest_done_in) begin
      n.lb_run = 1'b0;
    end

    // clear first, so a completion in the same cycle wins
    if (cls_now) begin
      n.sp_done = 1'b0;
      n.boot_done = 1'b0;
    end
    if (r.tests_on && !n.afe_run && !n.lb_run) begin
      n.tests_on = 1'b0;
      n.act_sel = 4'h0;
      n.sp_done = 1'b1;
    end
    if (boot_complete_in) begin
      n.boot_done = 1'b1;
    end

    // fault and warning latches; set beats clear
    fset[`ASRB_F_WAR] = |(r.warn & ~warn_mask_in);
    fset[`ASRB_F_UVD] = uv_supply_in;
    fset[`ASRB_F_UVA] = uv_reg_in;
    fset[`ASRB_F_RST] = r.hard_p;
    n.fault = (r.fault & ~(cle_now ? r.fsnap : 12'h000)) | fset;
    n.warn = (r.warn & ~(clw_now ? r.wsnap : 12'h000)) | wset;
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      r <= '0;
      r.sck_s <= 3'h7;
      r.cs_s <= 3'h7;
      r.sck_f <= 1'b1;
      r.cs_f <= 1'b1;
      r.fault <= `ASRB_FAULT_RESET;
    end else if (ce_in) begin
      r <= n;
    end
  end

  assign spi_miso_out = r.miso;
  assign spi_miso_oe_out = r.miso_oe;
  assign ext_read_addr_out = r.ra;
  assign ext_write_start_out = r.wr_start;
  assign margin_out = r.margin;
  assign turns_reset_out = r.turns_p;
  assign hard_reset_out = r.hard_p;
  assign nvm_reload_out = r.reload_p;
  assign afe_test_start_out = r.afe_p;
  assign logic_builtin_selftest_start_out = r.lb_p;

  sequence s_nvm_start;
    rgo && r.ra <= `ASRB_NVM_LAST && ce_in;
  endsequence
  sequence s_busy_hold;
    rd_busy && !r.rd_done;
  endsequence

  a_nvm_read_time: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in || !ce_in)
    s_nvm_start |=> s_busy_hold [*8])
    else $error("nvm read finished too early");
  a_busy_not_done: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    rd_busy |-> !r.rd_done)
    else $error("read busy and done together");
  a_angle_parity: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    ^ang_word && !ang_word[15])
    else $error("angle word parity wrong");
  a_fault_sticky: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in || !ce_in)
    (|(r.fault & ~n.fault)) |-> cle_now)
    else $error("fault bit dropped without clear");
  a_late_fault_kept: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in || !ce_in)
    cle_now |=> ((r.fault & $past(r.fault & ~r.fsnap)) == $past(r.fault & ~r.fsnap)))
    else $error("unseen fault cleared");
  a_uv_resets: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in || !ce_in)
    uv_supply_in |=> r.fault[`ASRB_F_UVD])
    else $error("supply fault not latched");
  a_bad_key: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in || !ce_in)
    key_wr && !key_ok && !r.tests_on |=> r.act_sel == $past(r.act_sel) && !r.hard_p)
    else $error("wrong key acted");
  a_trigger_done: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in || !ce_in)
    key_ok && r.act_sel == `ASRB_ACT_TURNS && !cls_now |=> r.sp_done && r.turns_p)
    else $error("turns reset not completed");
  a_overlap_warn: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in || !ce_in)
    (rgo || wgo) && (rd_busy || r.wr_busy) |=> r.warn[`ASRB_W_BSY])
    else $error("overlap warning missing");
endmodule
`default_nettype wire

// [sim/asrb_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module asrb_host_model (
  output logic sclk_out,
  output logic cs_n_out,
  output logic mosi_out,
  input wire logic miso_in
);
  localparam realtime HALF = 80.0;
  initial begin
    sclk_out = 1'b1;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
  end
  // whole 16-bit frames only; a read reply arrives in the following frame
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    cs_n_out = 1'b0;
    #(HALF);
    // the slave shifts on each falling edge, so its bit is taken just before it
    for (int i = 15; i >= 0; i--) begin
      rx[i] = miso_in;
      sclk_out = 1'b0;
      mosi_out = tx[i];
      #(HALF);
      sclk_out = 1'b1;
      #(HALF);
    end
    cs_n_out = 1'b1;
    // released line must not keep the last bit
    mosi_out = ~tx[0];
    #(HALF * 4);
  endtask
endmodule
`default_nettype wire

// [sim/asrb_bank_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module asrb_bank_tb_top;
  logic clk_sys_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic sclk, cs_n, mosi, miso, miso_oe;
  logic [11:0] angle = 12'h123;
  logic uv_s = 1'b0, uv_r = 1'b0, uv_sm = 1'b0, uv_rm = 1'b0;
  logic [11:0] fev = 12'h000, wev = 12'h000;
  logic [11:0] fmsk = 12'h000;
  logic oe_bad = 1'b0;
  logic unl = 1'b1, lock = 1'b1, bbusy = 1'b0, bdone = 1'b0, rot = 1'b1;
  logic [31:0] nvm = 32'h5a5a0f0f, shd = 32'h1234abcd;
  logic wdone = 1'b0, afed = 1'b0, lbd = 1'b0;
  logic [7:0] xaddr;
  logic xws, trs, hrs, nrl, afs, lbs;
  logic [1:0] marg;
  int errors = 0, check_count = 0;
  int pc[6] = '{0, 0, 0, 0, 0, 0};
  always #2.5 clk_sys_in = ~clk_sys_in;
  always @(negedge clk_sys_in) begin
    if (trs === 1'b1) pc[0]++;
    if (nrl === 1'b1) pc[1]++;
    if (hrs === 1'b1) pc[2]++;
    if (afs === 1'b1) pc[3]++;
    if (lbs === 1'b1) pc[4]++;
    if (xws === 1'b1) pc[5]++;
  end
  always @(posedge sclk) begin
    if (!cs_n && miso_oe !== 1'b1) oe_bad = 1'b1;
  end
  asrb_host_model host_u (.sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi), .miso_in(miso));
  asrb_bank dut_u (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .ce_in(1'b1),
    .spi_sclk_in(sclk), .spi_cs_n_in(cs_n), .spi_mosi_in(mosi), .spi_miso_out(miso),
    .spi_miso_oe_out(miso_oe), .angle_in(angle), .uv_supply_in(uv_s), .uv_reg_in(uv_r),
    .uv_supply_mask_in(uv_sm), .uv_reg_mask_in(uv_rm), .fault_event_in(fev),
    .fault_mask_in(fmsk), .warn_event_in(wev), .warn_mask_in(12'h000),
    .unlocked_in(unl), .loop_locked_in(lock), .boot_busy_in(bbusy),
    .boot_complete_in(bdone), .rot_dir_in(rot), .nvm_data_in(nvm), .shadow_data_in(shd),
    .ext_write_done_in(wdone), .afe_test_done_in(afed), .logic_builtin_selftest_done_in(lbd),
    .ext_read_addr_out(xaddr), .ext_write_start_out(xws), .margin_out(marg),
    .turns_reset_out(trs), .hard_reset_out(hrs), .nvm_reload_out(nrl),
    .afe_test_start_out(afs), .logic_builtin_selftest_start_out(lbs));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [15:0] r;
    host_u.xfer({2'b01, a, d}, r);
  endtask
  task automatic rc(input logic [5:0] a, input logic [15:0] exp);
    logic [15:0] r;
    host_u.xfer({2'b00, a, 8'h00}, r);
    host_u.xfer(16'h0000, r);
    chk(r, exp);
  endtask
  function automatic logic [15:0] angw(input logic ef, input logic uv, input logic [11:0] a);
    logic [15:0] w;
    w = {1'b0, ef, uv, 1'b0, a};
    w[12] = ~^w;
    return w;
  endfunction
  task automatic pulse(ref logic s);
    @(negedge clk_sys_in);
    s = 1'b1;
    @(negedge clk_sys_in);
    s = 1'b0;
  endtask

  task automatic test_faults();
    rc(6'h24, 16'ha001);
    @(negedge clk_sys_in);
    fev = 12'h010;
    @(negedge clk_sys_in);
    fev = 12'h000;
    wr(6'h1e, 8'h01);
    rc(6'h24, 16'ha010);
    wr(6'h1e, 8'h01);
    rc(6'h24, 16'ha000);
  endtask
  task automatic test_status();
    pulse(bdone);
    rc(6'h22, 16'h8091);
    wr(6'h1e, 8'h04);
    rc(6'h22, 16'h8081);
  endtask
  task automatic test_angle();
    rc(6'h20, angw(1'b0, 1'b0, 12'h123));
    @(negedge clk_sys_in);
    uv_s = 1'b1;
    angle = 12'hfff;
    rc(6'h20, angw(1'b1, 1'b1, 12'hfff));
    @(negedge clk_sys_in);
    uv_sm = 1'b1;
    uv_s = 1'b0;
    uv_r = 1'b1;
    rc(6'h20, angw(1'b1, 1'b1, 12'hfff));
    @(negedge clk_sys_in);
    uv_rm = 1'b1;
    rc(6'h20, angw(1'b1, 1'b0, 12'hfff));
    @(negedge clk_sys_in);
    uv_r = 1'b0;
    fmsk = 12'hfff;
    rc(6'h20, angw(1'b0, 1'b0, 12'hfff));
    @(negedge clk_sys_in);
    fmsk = 12'h000;
  endtask
  task automatic test_ext_read();
    wr(6'h0b, 8'h45);
    wr(6'h0c, 8'h80);
    chk({8'h00, xaddr}, 16'h0045);
    rc(6'h0c, 16'h0001);
    rc(6'h0e, 16'h1234);
    rc(6'h10, 16'habcd);
    wr(6'h0b, 8'h1f);
    wr(6'h0c, 8'h80);
    rc(6'h0c, 16'h0001);
    rc(6'h0e, 16'h5a5a);
    rc(6'h10, 16'h0f0f);
    wr(6'h0b, 8'h30);
    wr(6'h0c, 8'h80);
    rc(6'h0c, 16'h0001);
    rc(6'h26, 16'hb080);
  endtask
  task automatic test_ext_write();
    @(negedge clk_sys_in);
    unl = 1'b0;
    wr(6'h08, 8'h80);
    chk(16'(pc[5]), 16'h0000);
    rc(6'h08, 16'h0001);
    @(negedge clk_sys_in);
    unl = 1'b1;
    wr(6'h08, 8'h80);
    chk(16'(pc[5]), 16'h0001);
    rc(6'h08, 16'h0100);
    // read started while the write is still pending
    wr(6'h0c, 8'h80);
    rc(6'h26, 16'hb084);
    pulse(wdone);
    rc(6'h08, 16'h0001);
    @(negedge clk_sys_in);
    wev = 12'h020;
    @(negedge clk_sys_in);
    wev = 12'h000;
    wr(6'h1e, 8'h02);
    rc(6'h26, 16'hb020);
    chk({15'h0, miso_oe}, 16'h0000);
    chk({15'h0, oe_bad}, 16'h0000);
  endtask
  task automatic test_actions();
    logic [3:0] code[5] = '{4'h4, 4'h5, 4'h7, 4'h9, 4'ha};
    logic [7:0] key[5] = '{8'h46, 8'ha5, 8'h5a, 8'hb9, 8'hb9};
    int old;
    logic [15:0] r;
    logic [15:0] sta;
    @(negedge clk_sys_in);
    unl = 1'b0;
    wr(6'h1e, 8'h50);
    wr(6'h1f, 8'ha5);
    chk(16'(pc[1]), 16'h0000);
    @(negedge clk_sys_in);
    unl = 1'b1;
    wr(6'h1e, 8'h10);
    wr(6'h1f, 8'ha5);
    chk({14'h0, marg}, 16'h0001);
    rc(6'h1e, 16'h1000);
    for (int i = 0; i < 5; i++) begin
      old = pc[i];
      wr(6'h1e, {code[i], 4'h0});
      wr(6'h1f, 8'h11);
      chk(16'(pc[i] - old), 16'h0000);
      rc(6'h1e, {code[i], 12'h000});
      wr(6'h1f, key[i]);
      chk(16'(pc[i] - old), 16'h0001);
      sta = 16'h8081 | (i < 3 ? 16'h0020 : 16'h0000) | (i == 3 ? 16'h0004 : 16'h0000);
      sta = sta | (i == 4 ? 16'h0008 : 16'h0000);
      rc(6'h22, sta);
      pulse(afed);
      pulse(lbd);
      rc(6'h1e, 16'h0000);
      host_u.xfer(16'h2200, r);
      host_u.xfer(16'h0000, r);
      chk({15'h0, r[5]}, 16'h0001);
    end
    rc(6'h24, 16'ha80d);
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #450us;
    errors++;
    finish_test();
  end
  initial begin
    repeat (2) @(negedge clk_sys_in);
    arst_n_in = 1'b1;
    repeat (4) @(negedge clk_sys_in);
    test_faults();
    test_status();
    test_angle();
    test_ext_read();
    test_ext_write();
    test_actions();
    finish_test();
  end
endmodule
`default_nettype wire
